// ===== verilog/ulrt_top.sv
// Receive command builder and USB transmitter with input FIFO
// Operation
// - Bits 5:4 carry receive event code
// - Bit 6 shows ID pin level
// - Bit 7 flags unmasked alternate interrupt
// - Line state bits mirror D+ and D-
// - Shared bit-stuffing and NRZI for all speeds
// - Mode decoded from four config settings
// - High-speed packets get 32-bit sync
// - Full/low-speed packets get 8-bit sync
// - Chirp mode disables stuffing and NRZI
// - Host appends 40-bit EOP after high-speed SOF
// - Long EOP only with both pulldowns set
// - Peripheral never appends long EOP
// - Low-speed SOF gives two-bit SE0 keepalive
// - Bits 3:2 encode VBUS level
// - Send command on comparator change, or on line change while not transmitting
`timescale 1ns/1ns

module ulrt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg != (AW+1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

module ulrt_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Configuration
    input wire ulrt_pkg::ulrt_cfg_t cfg,
    // Pin status
    input wire logic dplus_in,
    input wire logic dminus_in,
    input wire logic id_pin,
    input wire ulrt_pkg::ulrt_vbus_t vbus,
    // Same-clock receiver status
    input wire logic rx_active,
    input wire logic rx_error,
    input wire logic host_disconnect_event,
    input wire logic alt_int_pending,
    // Transmit stream from the link
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    // Receive command output
    output logic [7:0] rx_cmd,
    output logic rx_cmd_send,
    // Line drive
    output ulrt_pkg::ulrt_line_t line_out,
    output logic tx_busy
);
    typedef enum logic [2:0] {
        ULRT_IDLE, ULRT_SYNC, ULRT_DATA, ULRT_EOP, ULRT_J, ULRT_KEEP
    } ulrt_state_t;

    // Three-flop synchronisers
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    logic [5:0] pin_reg;
    logic [5:0] pin_raw;

    assign pin_raw = {vbus.session_end, vbus.session_valid,
                      vbus.vbus_valid, id_pin, dminus_in, dplus_in};

    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_reg <= '0;
        end else if (clk_en) begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 6; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    function automatic logic [1:0] vbus_code(input logic [2:0] v);
        // v = {session_end, session_valid, vbus_valid}
        if (v[0]) begin
            return ulrt_pkg::VBUS_ABOVE_VBUS;
        end else if (v[1]) begin
            return ulrt_pkg::VBUS_VALID_TO_VBUS;
        end else if (!v[2]) begin
            return ulrt_pkg::VBUS_END_TO_VALID;
        end
        return ulrt_pkg::VBUS_BELOW_END;
    endfunction

    logic [1:0] event_code;
    always_comb begin
        if (host_disconnect_event) begin
            event_code = ulrt_pkg::EVT_DISCON;
        end else if (rx_active && rx_error) begin
            event_code = ulrt_pkg::EVT_ERROR;
        end else if (rx_active) begin
            event_code = ulrt_pkg::EVT_ACTIVE;
        end else begin
            event_code = ulrt_pkg::EVT_IDLE;
        end
    end

    logic [7:0] cmd_next;
    always_comb begin
        cmd_next = '0;
        cmd_next[ulrt_pkg::RX_LINE_LSB +: 2] = pin_reg[1:0];
        cmd_next[ulrt_pkg::RX_VBUS_LSB +: 2] = vbus_code(pin_reg[5:3]);
        cmd_next[ulrt_pkg::RX_EVENT_LSB +: 2] = event_code;
        cmd_next[ulrt_pkg::RX_ID_BIT] = pin_reg[2];
        // Masking is done outside the block
        cmd_next[ulrt_pkg::RX_ALT_BIT] = alt_int_pending;
    end

    logic [7:0] cmd_last_reg;
    logic tx_busy_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_cmd <= '0;
            rx_cmd_send <= 1'b0;
            cmd_last_reg <= '0;
        end else if (clk_en) begin
            rx_cmd <= cmd_next;
            rx_cmd_send <= 1'b0;
            // Own drive is not reported
            if (cmd_next[7:2] != cmd_last_reg[7:2] ||
                (!tx_busy_reg && cmd_next[1:0] != cmd_last_reg[1:0])) begin
                rx_cmd_send <= 1'b1;
                cmd_last_reg <= cmd_next;
            end
        end
    end

    // Transmit path
    logic [7:0] f_data;
    logic f_valid;
    logic f_ready;
    logic f_last_flag;

    ulrt_fifo #(
        .WIDTH(ulrt_pkg::FIFO_WIDTH + 1),
        .DEPTH(ulrt_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .in_data({tx_last, tx_data}),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data({f_last_flag, f_data}),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );

    ulrt_state_t state_reg;
    logic [5:0] cnt_reg;
    logic [7:0] bit_tmr_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_idx_reg;
    logic [2:0] ones_reg;
    logic nrzi_reg;
    logic last_reg;
    logic long_eop_reg;
    logic raw_mode_reg;
    logic [1:0] speed_reg;

    function automatic logic [7:0] bit_cycles(input logic [1:0] spd);
        unique case (spd)
            ulrt_pkg::SPEED_HS: return ulrt_pkg::HS_BIT_CYCLES;
            ulrt_pkg::SPEED_LS: return ulrt_pkg::LS_BIT_CYCLES;
            ulrt_pkg::SPEED_FS, ulrt_pkg::SPEED_FS4LS:
                return ulrt_pkg::FS_BIT_CYCLES;
        endcase
    endfunction

    logic host_mode;
    logic is_sof;
    logic tx_allowed;
    logic bit_tick;
    logic cur_bit;
    logic stuff_now;
    assign host_mode = cfg.dplus_pulldown_enable &&
                       cfg.dminus_pulldown_enable;
    assign is_sof = f_data[7:6] == ulrt_pkg::TXCMD_TYPE &&
                    f_data[5:4] == ulrt_pkg::TXCMD_SUB &&
                    f_data[3:0] == ulrt_pkg::PID_SOF;
    assign tx_allowed = cfg.op_mode != ulrt_pkg::OPMODE_NODRIVE;
    assign bit_tick = bit_tmr_reg == 8'h01;
    assign cur_bit = shift_reg[0];
    assign stuff_now = !raw_mode_reg && ones_reg == ulrt_pkg::STUFF_LIMIT;
    // Command pops at start; data bytes pop at byte end
    assign f_ready = clk_en && f_valid && (
        (state_reg == ULRT_IDLE && tx_allowed) ||
        (state_reg == ULRT_DATA && bit_tick && !stuff_now &&
         bit_idx_reg == 4'h7 && !last_reg));

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ULRT_IDLE;
            cnt_reg <= '0;
            bit_tmr_reg <= 8'h01;
            shift_reg <= '0;
            bit_idx_reg <= '0;
            ones_reg <= '0;
            nrzi_reg <= 1'b1;
            last_reg <= 1'b0;
            long_eop_reg <= 1'b0;
            raw_mode_reg <= 1'b0;
            speed_reg <= ulrt_pkg::SPEED_FS;
            line_out <= '0;
            tx_busy_reg <= 1'b0;
            tx_busy <= 1'b0;
        end else if (clk_en) begin
            tx_busy <= tx_busy_reg;
            if (state_reg != ULRT_IDLE) begin
                bit_tmr_reg <= bit_tick ? bit_cycles(speed_reg)
                                        : bit_tmr_reg - 8'h01;
            end
            unique case (state_reg)
                ULRT_IDLE: begin
                    line_out <= '0;
                    tx_busy_reg <= 1'b0;
                    if (f_valid && tx_allowed) begin
                        speed_reg <= cfg.speed_select;
                        raw_mode_reg <= cfg.op_mode ==
                                        ulrt_pkg::OPMODE_CHIRP;
                        long_eop_reg <= is_sof && host_mode &&
                            cfg.speed_select == ulrt_pkg::SPEED_HS;
                        last_reg <= f_last_flag;
                        bit_tmr_reg <= bit_cycles(cfg.speed_select);
                        nrzi_reg <= 1'b1;
                        ones_reg <= '0;
                        bit_idx_reg <= '0;
                        // PID then its complement
                        shift_reg <= {~f_data[3:0], f_data[3:0]};
                        tx_busy_reg <= 1'b1;
                        if (is_sof &&
                            cfg.speed_select == ulrt_pkg::SPEED_LS) begin
                            state_reg <= ULRT_KEEP;
                            cnt_reg <= ulrt_pkg::KEEPALIVE_BITS;
                        end else if (cfg.op_mode ==
                                     ulrt_pkg::OPMODE_CHIRP) begin
                            state_reg <= ULRT_DATA;
                        end else begin
                            state_reg <= ULRT_SYNC;
                            cnt_reg <= cfg.speed_select ==
                                       ulrt_pkg::SPEED_HS
                                ? ulrt_pkg::HS_SYNC_BITS
                                : ulrt_pkg::FS_SYNC_BITS;
                        end
                    end
                end
                ULRT_SYNC: if (bit_tick) begin
                    // Sync is KJKJ...KK: the last bit holds the line
                    if (cnt_reg != 6'h01) begin
                        nrzi_reg <= ~nrzi_reg;
                        line_out <= '{dp: ~nrzi_reg, dm: nrzi_reg, oe: 1'b1};
                    end else begin
                        line_out <= '{dp: nrzi_reg, dm: ~nrzi_reg, oe: 1'b1};
                    end
                    cnt_reg <= cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        state_reg <= ULRT_DATA;
                    end
                end
                ULRT_DATA: if (bit_tick) begin
                    if (raw_mode_reg) begin
                        line_out <= '{dp: cur_bit, dm: ~cur_bit, oe: 1'b1};
                    end else if (stuff_now || !cur_bit) begin
                        // Zero or stuffed bit toggles the line
                        line_out <= '{dp: ~nrzi_reg, dm: nrzi_reg,
                                      oe: 1'b1};
                        nrzi_reg <= ~nrzi_reg;
                    end else begin
                        line_out <= '{dp: nrzi_reg, dm: ~nrzi_reg, oe: 1'b1};
                    end
                    if (stuff_now) begin
                        ones_reg <= '0;
                    end else begin
                        ones_reg <= cur_bit ? ones_reg + 3'h1 : 3'h0;
                        shift_reg <= {1'b0, shift_reg[7:1]};
                        bit_idx_reg <= bit_idx_reg + 4'h1;
                        if (bit_idx_reg == 4'h7) begin
                            bit_idx_reg <= '0;
                            if (last_reg) begin
                                // Chirp has no encoded EOP
                                state_reg <= raw_mode_reg ? ULRT_IDLE
                                                          : ULRT_EOP;
                                cnt_reg <= speed_reg == ulrt_pkg::SPEED_HS
                                    ? (long_eop_reg
                                       ? ulrt_pkg::HS_LONG_EOP_BITS
                                       : ulrt_pkg::HS_EOP_BITS)
                                    : ulrt_pkg::FS_SE0_BITS;
                            end else if (f_valid) begin
                                shift_reg <= f_data;
                                last_reg <= f_last_flag;
                            end else begin
                                // Underrun: close the packet cleanly
                                state_reg <= ULRT_EOP;
                                cnt_reg <= ulrt_pkg::FS_SE0_BITS;
                            end
                        end
                    end
                end
                ULRT_EOP: if (bit_tick) begin
                    if (speed_reg == ulrt_pkg::SPEED_HS) begin
                        // HS EOP is a run of stuffing violations
                        line_out <= '{dp: ~nrzi_reg, dm: nrzi_reg,
                                      oe: 1'b1};
                    end else begin
                        line_out <= '{dp: 1'b0, dm: 1'b0, oe: 1'b1};
                    end
                    cnt_reg <= cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        state_reg <= speed_reg == ulrt_pkg::SPEED_HS
                                     ? ULRT_IDLE : ULRT_J;
                    end
                end
                ULRT_J: if (bit_tick) begin
                    line_out <= '{dp: speed_reg != ulrt_pkg::SPEED_LS,
                                  dm: speed_reg == ulrt_pkg::SPEED_LS,
                                  oe: 1'b1};
                    state_reg <= ULRT_IDLE;
                end
                ULRT_KEEP: if (bit_tick) begin
                    line_out <= '{dp: 1'b0, dm: 1'b0, oe: 1'b1};
                    cnt_reg <= cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        state_reg <= ULRT_J;
                    end
                end
            endcase
        end
    end
endmodule

// ===== verilog/ulrt_pkg.sv
// Constants and carrier types for the block
package ulrt_pkg;
    // Receive command byte fields
    localparam int RX_LINE_LSB = 0;
    localparam int RX_VBUS_LSB = 2;
    localparam int RX_EVENT_LSB = 4;
    localparam int RX_ID_BIT = 6;
    localparam int RX_ALT_BIT = 7;
    localparam logic [1:0] EVT_IDLE = 2'h0;
    localparam logic [1:0] EVT_ACTIVE = 2'h1;
    localparam logic [1:0] EVT_DISCON = 2'h2;
    localparam logic [1:0] EVT_ERROR = 2'h3;
    localparam logic [1:0] VBUS_BELOW_END = 2'h0;
    localparam logic [1:0] VBUS_END_TO_VALID = 2'h1;
    localparam logic [1:0] VBUS_VALID_TO_VBUS = 2'h2;
    localparam logic [1:0] VBUS_ABOVE_VBUS = 2'h3;
    // Transmit command
    localparam logic [1:0] TXCMD_TYPE = 2'h1;
    localparam logic [1:0] TXCMD_SUB = 2'h0;
    localparam logic [3:0] PID_SOF = 4'h5;
    // Speed and operating modes
    localparam logic [1:0] SPEED_HS = 2'h0;
    localparam logic [1:0] SPEED_FS = 2'h1;
    localparam logic [1:0] SPEED_LS = 2'h2;
    localparam logic [1:0] SPEED_FS4LS = 2'h3;
    localparam logic [1:0] OPMODE_NORMAL = 2'h0;
    localparam logic [1:0] OPMODE_NODRIVE = 2'h1;
    localparam logic [1:0] OPMODE_CHIRP = 2'h2;
    // Bit counts
    localparam logic [5:0] HS_SYNC_BITS = 6'h20;
    localparam logic [5:0] FS_SYNC_BITS = 6'h08;
    localparam logic [5:0] HS_LONG_EOP_BITS = 6'h28;
    localparam logic [5:0] HS_EOP_BITS = 6'h08;
    localparam logic [5:0] FS_SE0_BITS = 6'h02;
    localparam logic [5:0] KEEPALIVE_BITS = 6'h02;
    localparam logic [2:0] STUFF_LIMIT = 3'h6;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    // Clock cycles per line bit
    localparam logic [7:0] HS_BIT_CYCLES = 8'h01;
    localparam logic [7:0] FS_BIT_CYCLES = 8'h01;
    localparam logic [7:0] LS_BIT_CYCLES = 8'h0D;

    typedef struct packed {
        logic [1:0] speed_select;
        logic termination_select;
        logic [1:0] op_mode;
        logic dplus_pulldown_enable;
        logic dminus_pulldown_enable;
    } ulrt_cfg_t;

    typedef struct packed {
        logic session_end;
        logic session_valid;
        logic vbus_valid;
    } ulrt_vbus_t;

    typedef struct packed {
        logic dp;
        logic dm;
        logic oe;
    } ulrt_line_t;
endpackage

// ===== sim/ulrt_props.sv
// Assertions on receive command and line outputs
`timescale 1ns/1ns
module ulrt_props (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Inputs seen by the block
    input wire ulrt_pkg::ulrt_cfg_t cfg,
    input wire logic dplus_in,
    input wire logic dminus_in,
    input wire logic id_pin,
    input wire ulrt_pkg::ulrt_vbus_t vbus,
    input wire logic rx_active,
    input wire logic rx_error,
    input wire logic host_disconnect_event,
    input wire logic alt_int_pending,
    // Outputs
    input wire logic [7:0] rx_cmd,
    input wire logic rx_cmd_send,
    input wire ulrt_pkg::ulrt_line_t line_out,
    input wire logic tx_busy
);
    logic [1:0] evt_now;
    logic [1:0] vb_now;
    logic jst;
    logic kst;
    assign evt_now = host_disconnect_event ? 2'h2 : {rx_error, rx_active};
    assign vb_now = vbus.vbus_valid ? 2'h3 : vbus.session_valid ? 2'h2 :
        vbus.session_end ? 2'h0 : 2'h1;
    assign jst = line_out.dp && !line_out.dm;
    assign kst = !line_out.dp && line_out.dm;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence fs_start_s;
        $rose(line_out.oe) && clk_en && cfg.op_mode == 2'h0 &&
        cfg.speed_select == ulrt_pkg::SPEED_FS;
    endsequence
    sequence fs_sync_s;
        kst ##1 jst ##1 kst ##1 jst ##1 kst ##1 jst ##1 kst ##1 kst;
    endsequence
    event_code_a: assert property (
        clk_en && !(rx_error && !rx_active) |=> rx_cmd[5:4] == $past(evt_now))
        else $error("Receive event code wrong");
    alt_flag_a: assert property (
        clk_en |=> rx_cmd[7] == $past(alt_int_pending))
        else $error("Alternate interrupt flag wrong");
    id_level_a: assert property (
        (clk_en && $stable(id_pin))[*8] |-> rx_cmd[6] == id_pin)
        else $error("ID level not shown");
    vbus_code_a: assert property (
        (clk_en && $stable(vbus))[*8] |-> rx_cmd[3:2] == vb_now)
        else $error("VBUS code wrong");
    line_state_a: assert property (
        (clk_en && $stable(dplus_in) && $stable(dminus_in))[*8]
        |-> rx_cmd[1:0] == {dminus_in, dplus_in})
        else $error("Line state wrong");
    cmd_notify_a: assert property (
        clk_en && $changed(rx_cmd[7:2]) |-> ##[0:1] rx_cmd_send)
        else $error("Receive command not sent on change");
    fs_sync_a: assert property (fs_start_s |-> fs_sync_s)
        else $error("Full-speed sync pattern wrong");
    idle_drive_a: assert property (
        (!tx_busy)[*3] |-> !line_out.oe)
        else $error("Line driven outside a packet");
endmodule

bind ulrt_top ulrt_props u_props (.clk(clk), .reset(reset), .clk_en(clk_en),
    .cfg(cfg), .dplus_in(dplus_in), .dminus_in(dminus_in), .id_pin(id_pin),
    .vbus(vbus), .rx_active(rx_active), .rx_error(rx_error),
    .host_disconnect_event(host_disconnect_event),
    .alt_int_pending(alt_int_pending), .rx_cmd(rx_cmd),
    .rx_cmd_send(rx_cmd_send), .line_out(line_out), .tx_busy(tx_busy));

// ===== sim/ulrt_link_model.sv
// Link model: sends packets, clears alternate interrupts
`timescale 1ns/1ns
module ulrt_link_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Transmit stream
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    // Receive command and interrupt latch
    input wire logic [7:0] rx_cmd,
    input wire logic rx_cmd_send,
    input wire logic alt_raise,
    output logic alt_int_pending
);
    logic [7:0] pkt[$];
    initial {tx_data, tx_valid, tx_last} = '0;
    // Call after a clock edge; each byte held until taken
    task automatic send(input logic [3:0] pid);
        for (int k = 0; k <= pkt.size(); k++) begin
            tx_data <= k ? pkt[k-1] :
                {ulrt_pkg::TXCMD_TYPE, ulrt_pkg::TXCMD_SUB, pid};
            tx_valid <= 1'b1;
            tx_last <= (k == pkt.size());
            @(posedge clk);
            while (!(tx_ready && clk_en))
                @(posedge clk);
        end
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        // Released data must not look like the last byte
        tx_data <= ~tx_data;
    endtask
    always_ff @(posedge clk) begin
        if (reset)
            alt_int_pending <= 1'b0;
        else if (alt_raise)
            alt_int_pending <= 1'b1;
        else if (rx_cmd_send && rx_cmd[7])
            alt_int_pending <= 1'b0;
    end
endmodule

// ===== sim/tb.sv
// Bench for the receive command and transmitter
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    ulrt_pkg::ulrt_cfg_t cfg = '0;
    logic dplus_in = 1'b1, dminus_in = 1'b0, id_pin = 1'b1;
    ulrt_pkg::ulrt_vbus_t vbus = 3'h7;
    logic rx_active = 1'b0, rx_error = 1'b0, alt_raise = 1'b0;
    logic host_disconnect_event = 1'b0;
    logic alt_int_pending, tx_valid, tx_last, tx_ready, rx_cmd_send, tx_busy;
    logic [7:0] tx_data, rx_cmd;
    ulrt_pkg::ulrt_line_t line_out;
    int n_mismatch = 0;
    int check_count = 0;
    int i, ones, hs_base;
    logic [1:0] lvl, cap[$], expq[$];
    logic en_d = 1'b0, alt_seen = 1'b0;
    logic [2:0] ev_in[4] = '{3'h0, 3'h4, 3'h6, 3'h1};
    logic [1:0] ev_out[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [2:0] vb_in[5] = '{3'h4, 3'h0, 3'h2, 3'h6, 3'h7};
    logic [1:0] vb_out[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};

    always #25 clk = ~clk;
    // One line sample per enabled cycle; frozen cycles drop out
    always @(posedge clk) begin
        en_d <= clk_en;
        if (en_d && line_out.oe) cap.push_back({line_out.dp, line_out.dm});
        if (rx_cmd[7]) alt_seen <= 1'b1;
    end

    ulrt_top u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .cfg(cfg),
        .dplus_in(dplus_in), .dminus_in(dminus_in), .id_pin(id_pin),
        .vbus(vbus), .rx_active(rx_active), .rx_error(rx_error),
        .host_disconnect_event(host_disconnect_event),
        .alt_int_pending(alt_int_pending), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .rx_cmd(rx_cmd), .rx_cmd_send(rx_cmd_send), .line_out(line_out),
        .tx_busy(tx_busy));
    ulrt_link_model u_link (.clk(clk), .reset(reset), .clk_en(clk_en),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .rx_cmd(rx_cmd), .rx_cmd_send(rx_cmd_send),
        .alt_raise(alt_raise), .alt_int_pending(alt_int_pending));

    function automatic void put_bit(input logic b);
        if (!b) lvl = ~lvl;
        expq.push_back(lvl);
        ones = b ? ones + 1 : 0;
        if (ones == 6) begin
            lvl = ~lvl;
            expq.push_back(lvl);
            ones = 0;
        end
    endfunction
    function automatic int count_se0();
        int n = 0;
        foreach (cap[k]) if (cap[k] == 2'h0) n++;
        return n;
    endfunction
    function automatic int run_len();
        int n = 0;
        while (n < cap.size() && cap[n] != 2'h0) n++;
        return n;
    endfunction
    task automatic build_fs(input logic [3:0] pid);
        logic [7:0] b;
        expq.delete();
        lvl = 2'h2;
        ones = 0;
        for (int j = 0; j < 8; j++) put_bit(j == 7);
        for (int k = 0; k <= u_link.pkt.size(); k++) begin
            b = k ? u_link.pkt[k-1] : {~pid, pid};
            for (int j = 0; j < 8; j++) put_bit(b[j]);
        end
    endtask
    // Mode changes only when the line is idle again
    task automatic set_cfg(input logic [1:0] spd, input logic [1:0] op,
            input logic host);
        @(posedge clk);
        cfg <= {spd, spd != 2'h0 || op == ulrt_pkg::OPMODE_CHIRP, op, host,
            host};
    endtask
    task automatic wait_idle();
        int n = 0;
        while (tx_busy !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        while (tx_busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        `CHECK("tx_idle", 1'b0, line_out.oe)
    endtask
    task automatic run_pkt(input logic [3:0] pid);
        cap.delete();
        u_link.send(pid);
        wait_idle();
    endtask
    task automatic cmp_fs();
        foreach (expq[k]) `CHECK("fs_bits", expq[k], cap[k])
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        hs_base = ulrt_pkg::HS_SYNC_BITS + 24;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        for (i = 0; i < 4; i++) begin
            {rx_active, rx_error, host_disconnect_event} <= ev_in[i];
            repeat (3) @(posedge clk);
            `CHECK("rx_event", ev_out[i], rx_cmd[5:4])
        end
        for (i = 0; i < 5; i++) begin
            vbus <= vb_in[i];
            repeat (10) @(posedge clk);
            `CHECK("vbus_code", vb_out[i], rx_cmd[3:2])
        end
        for (i = 0; i < 4; i++) begin
            {dminus_in, dplus_in} <= i[1:0];
            id_pin <= i[0];
            repeat (10) @(posedge clk);
            `CHECK("line_state", i[1:0], rx_cmd[1:0])
            `CHECK("id_level", i[0], rx_cmd[6])
        end
        {dminus_in, dplus_in} <= 2'h1;
        alt_raise <= 1'b1;
        @(posedge clk);
        alt_raise <= 1'b0;
        repeat (10) @(posedge clk);
        `CHECK("alt_flag", 1'b1, alt_seen)
        `CHECK("alt_clear", 1'b0, alt_int_pending)
        $display("test rx_cmd done");
        // Full speed with a stuffed run and a freeze in mid-packet
        set_cfg(ulrt_pkg::SPEED_FS, ulrt_pkg::OPMODE_NORMAL, 1'b0);
        u_link.pkt = {8'hFF, 8'h01};
        build_fs(4'h3);
        fork
            run_pkt(4'h3);
            begin
                repeat (20) @(posedge clk);
                clk_en <= 1'b0;
                repeat (4) @(posedge clk);
                clk_en <= 1'b1;
            end
        join
        cmp_fs();
        `CHECK("fs_eop", ulrt_pkg::FS_SE0_BITS, count_se0())
        $display("test fs_packet done");
        u_link.pkt = {8'h00, 8'h00};
        set_cfg(ulrt_pkg::SPEED_HS, ulrt_pkg::OPMODE_NORMAL, 1'b1);
        run_pkt(ulrt_pkg::PID_SOF);
        `CHECK("hs_host_sof", hs_base + 40, cap.size())
        run_pkt(4'h3);
        `CHECK("hs_host_data", hs_base + 8, cap.size())
        set_cfg(ulrt_pkg::SPEED_HS, ulrt_pkg::OPMODE_NORMAL, 1'b0);
        run_pkt(ulrt_pkg::PID_SOF);
        `CHECK("hs_dev_sof", hs_base + 8, cap.size())
        $display("test hs_eop done");
        u_link.pkt.delete();
        set_cfg(ulrt_pkg::SPEED_LS, ulrt_pkg::OPMODE_NORMAL, 1'b1);
        run_pkt(ulrt_pkg::PID_SOF);
        `CHECK("keepalive", 2 * ulrt_pkg::LS_BIT_CYCLES, count_se0())
        $display("test keepalive done");
        u_link.pkt = {8'hFF, 8'hFF};
        set_cfg(ulrt_pkg::SPEED_HS, ulrt_pkg::OPMODE_CHIRP, 1'b0);
        run_pkt(4'h0);
        `CHECK("chirp_raw", 24, run_len())
        $display("test chirp done");
        // Held packet fills the buffer, then drains
        set_cfg(ulrt_pkg::SPEED_FS, ulrt_pkg::OPMODE_NODRIVE, 1'b0);
        u_link.pkt.delete();
        for (i = 0; i < 15; i++) u_link.pkt.push_back(8'h00);
        cap.delete();
        u_link.send(4'h3);
        @(posedge clk);
        `CHECK("fifo_full", 1'b0, tx_ready)
        `CHECK("held_idle", 1'b0, line_out.oe)
        build_fs(4'h3);
        set_cfg(ulrt_pkg::SPEED_FS, ulrt_pkg::OPMODE_NORMAL, 1'b0);
        wait_idle();
        cmp_fs();
        `CHECK("fifo_empty", 1'b1, tx_ready)
        $display("test fifo done");
        stop_test();
    end
endmodule
